/* rtl/vhr_cfg.svh */
// register map, field positions and reset values of the header remapper
`ifndef VHR_CFG_SVH
`define VHR_CFG_SVH
// ****************************************************************
// register offsets
// ****************************************************************
`define VHR_A_VC_OVR 16'h0314
`define VHR_A_DT_OVR_HI 16'h0316
`define VHR_A_DT_OVR_LO 16'h0317
`define VHR_A_BPP_OVR 16'h0319
`define VHR_A_OVR_EN 16'h031d
`define VHR_A_LANE_VCX 16'h044a
`define VHR_A_MAP_EN_LO 16'h044b
`define VHR_A_MAP_EN_HI 16'h044c
`define VHR_A_MAP_FIRST 16'h044d
`define VHR_A_MAP_LAST 16'h046c
`define VHR_A_EXT_FIRST 16'h0510
`define VHR_A_EXT_LAST 16'h051f
// ****************************************************************
// field positions
// ****************************************************************
`define VHR_VC_OVR_MSB 7
`define VHR_VC_OVR_LSB 4
`define VHR_DT_HI_MSB 7
`define VHR_DT_HI_LSB 6
`define VHR_DT_LO_MSB 3
`define VHR_DT_LO_LSB 0
`define VHR_BPP_MSB 4
`define VHR_BPP_LSB 0
`define VHR_OVR_EN_BIT 7
`define VHR_LANE_MSB 7
`define VHR_LANE_LSB 6
`define VHR_VCX_BIT 4
`define VHR_MAP_VC_MSB 7
`define VHR_MAP_VC_LSB 6
`define VHR_MAP_DT_MSB 5
`define VHR_MAP_DT_LSB 0
`define VHR_EXT_SRC_MSB 6
`define VHR_EXT_SRC_LSB 5
`define VHR_EXT_DST_MSB 3
`define VHR_EXT_DST_LSB 2
// ****************************************************************
// reset values
// ****************************************************************
`define VHR_RST_BYTE 8'h00
`define VHR_RST_LANE 2'h3
`define VHR_RST_MAP_EN 16'h0000
`endif

/* rtl/vhr_pkg.sv */
// types shared by the header remapper files
package vhr_pkg;
   typedef logic [5:0] vhr_dt_t;
   typedef logic [3:0] vhr_vc_t;
   typedef logic [4:0] vhr_bpp_t;
   typedef logic [7:0] vhr_byte_t;
   typedef logic [15:0] vhr_addr_t;
endpackage

/* rtl/vhr_skid_buf.sv */
// two-entry buffer with valid and ready on both sides
module vhr_skid_buf
   import vhr_pkg::*;
#(
   parameter int W = 8
)
(
   input wire logic i_sys_clk,
   input wire logic i_rst,
   input wire logic i_in_valid,
   output logic o_in_ready,
   input wire logic [W-1:0] i_in_data,
   output logic o_out_valid,
   input wire logic i_out_ready,
   output logic [W-1:0] o_out_data
);
   logic skid_valid;
   logic [W-1:0] skid_data;
   // ****************************************************************
   // next state of head and spare entry
   // ****************************************************************
   wire in_fire = i_in_valid && o_in_ready;
   wire load_out = !o_out_valid || i_out_ready;
   wire next_out_valid = load_out ? (skid_valid || in_fire) : 1'b1;
   wire [W-1:0] next_out_data = !load_out ? o_out_data :
                                (skid_valid ? skid_data : i_in_data);
   wire next_skid_valid = !load_out && (skid_valid || in_fire);
   wire [W-1:0] next_skid_data = (in_fire && !load_out) ? i_in_data
                                                         : skid_data;
   // head register, spare register and registered ready
   always_ff @(posedge i_sys_clk)
   begin
      if (i_rst)
      begin
         o_out_valid <= 1'b0;
         o_out_data <= '0;
         skid_valid <= 1'b0;
         skid_data <= '0;
         o_in_ready <= 1'b0;
      end
      else
      begin
         o_out_valid <= next_out_valid;
         o_out_data <= (in_fire || skid_valid) ? next_out_data : o_out_data;
         skid_valid <= next_skid_valid;
         skid_data <= next_skid_data;
         o_in_ready <= !next_skid_valid;
      end
   end
   // ****************************************************************
   // checks
   // ****************************************************************
   a_buf_hold_stall: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      o_out_valid && !i_out_ready |=> o_out_valid && $stable(o_out_data))
      else $error("head word changed while stalled");
   a_buf_full_stop: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      skid_valid |-> !o_in_ready)
      else $error("ready high with both entries full");
endmodule

/* rtl/vhr_remap.sv */
// video header override and virtual channel remapping stage
`include "vhr_cfg.svh"
module vhr_remap
   import vhr_pkg::*;
#(
   parameter int DATA_W = 32,
   parameter int MAP_N = 16
)
(
   input wire logic i_sys_clk,
   input wire logic i_rst,
   // register port
   input wire logic [15:0] i_reg_addr,
   input wire logic i_reg_wr,
   input wire logic [7:0] i_reg_wdata,
   input wire logic i_reg_rd,
   output logic [7:0] o_reg_rdata,
   output logic o_reg_rvalid,
   // stream from the video pipe
   input wire logic i_pix_valid,
   output logic o_pix_ready,
   input wire logic [5:0] i_pix_dt,
   input wire logic [3:0] i_pix_vc,
   input wire logic [4:0] i_pix_bpp,
   input wire logic [DATA_W-1:0] i_pix_data,
   // stream to the output controller
   output logic o_csi_valid,
   input wire logic i_csi_ready,
   output logic [5:0] o_csi_dt,
   output logic [3:0] o_csi_vc,
   output logic [4:0] o_csi_bpp,
   output logic [DATA_W-1:0] o_csi_data,
   // status
   output logic o_channel_extension_enable,
   output logic [1:0] o_lane_count
);
   localparam int HW = 6 + 4 + 5;
   localparam int BW = HW + DATA_W;

   // ****************************************************************
   // configuration storage
   // ****************************************************************
   vhr_vc_t override_channel_field;
   logic [1:0] dt_hi;
   logic [3:0] dt_lo;
   vhr_bpp_t override_bpp_field;
   logic header_override_enable;
   logic channel_extension_enable;
   logic [1:0] lane_count;
   logic [MAP_N-1:0] map_en;
   vhr_byte_t mapping_source_entry [MAP_N];
   vhr_byte_t mapping_dest_entry [MAP_N];
   vhr_byte_t ext_entry [MAP_N];

   // ****************************************************************
   // address decode
   // ****************************************************************
   wire sel_vc = i_reg_addr == `VHR_A_VC_OVR;
   wire sel_dt_hi = i_reg_addr == `VHR_A_DT_OVR_HI;
   wire sel_dt_lo = i_reg_addr == `VHR_A_DT_OVR_LO;
   wire sel_bpp = i_reg_addr == `VHR_A_BPP_OVR;
   wire sel_en = i_reg_addr == `VHR_A_OVR_EN;
   wire sel_lane = i_reg_addr == `VHR_A_LANE_VCX;
   wire sel_men_lo = i_reg_addr == `VHR_A_MAP_EN_LO;
   wire sel_men_hi = i_reg_addr == `VHR_A_MAP_EN_HI;
   wire sel_map = (i_reg_addr >= `VHR_A_MAP_FIRST) &&
                  (i_reg_addr <= `VHR_A_MAP_LAST);
   wire sel_ext = (i_reg_addr >= `VHR_A_EXT_FIRST) &&
                  (i_reg_addr <= `VHR_A_EXT_LAST);
   wire [15:0] map_off = i_reg_addr - `VHR_A_MAP_FIRST;
   wire [3:0] map_idx = map_off[4:1]; // two bytes per entry
   wire map_is_dst = map_off[0];
   wire [15:0] ext_off = i_reg_addr - `VHR_A_EXT_FIRST;
   wire [3:0] ext_idx = ext_off[3:0];

   // ****************************************************************
   // register writes
   // ****************************************************************
   // scalar control registers, documented bits only
   always_ff @(posedge i_sys_clk)
   begin
      if (i_rst)
      begin
         override_channel_field <= '0;
         dt_hi <= '0;
         dt_lo <= '0;
         override_bpp_field <= '0;
         header_override_enable <= 1'b0;
         channel_extension_enable <= 1'b0;
         lane_count <= `VHR_RST_LANE;
         map_en <= `VHR_RST_MAP_EN;
      end
      else if (i_reg_wr)
      begin
         if (sel_vc)
            override_channel_field <=
               i_reg_wdata[`VHR_VC_OVR_MSB:`VHR_VC_OVR_LSB];
         if (sel_dt_hi)
            dt_hi <= i_reg_wdata[`VHR_DT_HI_MSB:`VHR_DT_HI_LSB];
         if (sel_dt_lo)
            dt_lo <= i_reg_wdata[`VHR_DT_LO_MSB:`VHR_DT_LO_LSB];
         if (sel_bpp)
            override_bpp_field <=
               i_reg_wdata[`VHR_BPP_MSB:`VHR_BPP_LSB];
         if (sel_en)
            header_override_enable <= i_reg_wdata[`VHR_OVR_EN_BIT];
         if (sel_lane)
         begin
            lane_count <= i_reg_wdata[`VHR_LANE_MSB:`VHR_LANE_LSB];
            channel_extension_enable <= i_reg_wdata[`VHR_VCX_BIT];
         end
         if (sel_men_lo)
            map_en[7:0] <= i_reg_wdata;
         if (sel_men_hi)
            map_en[15:8] <= i_reg_wdata;
      end
   end

   // mapping and extension tables, indexed by entry
   always_ff @(posedge i_sys_clk)
   begin
      if (i_rst)
      begin
         for (int k = 0; k < MAP_N; k++)
         begin
            mapping_source_entry[k] <= `VHR_RST_BYTE;
            mapping_dest_entry[k] <= `VHR_RST_BYTE;
            ext_entry[k] <= `VHR_RST_BYTE;
         end
      end
      else if (i_reg_wr)
      begin
         if (sel_map && !map_is_dst)
            mapping_source_entry[map_idx] <= i_reg_wdata;
         if (sel_map && map_is_dst)
            mapping_dest_entry[map_idx] <= i_reg_wdata;
         if (sel_ext)
            ext_entry[ext_idx] <= {i_reg_wdata[7:2], 2'h0};
      end
   end

   // ****************************************************************
   // register reads
   // ****************************************************************
   // read data assembled from the selected register, zero when unmapped
   wire [7:0] rd_map = map_is_dst ? mapping_dest_entry[map_idx]
                                  : mapping_source_entry[map_idx];
   wire [7:0] next_rdata =
      sel_vc ? {override_channel_field, 4'h0} :
      sel_dt_hi ? {dt_hi, 6'h00} :
      sel_dt_lo ? {4'h0, dt_lo} :
      sel_bpp ? {3'h0, override_bpp_field} :
      sel_en ? {header_override_enable, 7'h00} :
      sel_lane ? {lane_count, 1'b0, channel_extension_enable, 4'h0} :
      sel_men_lo ? map_en[7:0] :
      sel_men_hi ? map_en[15:8] :
      sel_map ? rd_map :
      sel_ext ? ext_entry[ext_idx] : 8'h00;

   // read answer one edge after the strobe
   always_ff @(posedge i_sys_clk)
   begin
      if (i_rst)
      begin
         o_reg_rdata <= 8'h00;
         o_reg_rvalid <= 1'b0;
      end
      else
      begin
         o_reg_rvalid <= i_reg_rd;
         o_reg_rdata <= i_reg_rd ? next_rdata : o_reg_rdata;
      end
   end

   // ****************************************************************
   // software override stage
   // ****************************************************************
   // replace the pipe header only while the enable bit is set
   wire [5:0] ov_dt = header_override_enable ? {dt_hi, dt_lo}
                                             : i_pix_dt;
   wire [3:0] ov_vc = header_override_enable ? override_channel_field
                                             : i_pix_vc;
   wire [4:0] ov_bpp = header_override_enable ? override_bpp_field
                                              : i_pix_bpp;

   // ****************************************************************
   // mapping stage
   // ****************************************************************
   // per entry: wide source channel, wide destination channel, match
   logic [MAP_N-1:0] hit;
   logic [3:0] src_vc [MAP_N];
   logic [3:0] dst_vc [MAP_N];
   for (genvar g = 0; g < MAP_N; g++)
   begin : g_entry
      assign src_vc[g] = channel_extension_enable ?
         {ext_entry[g][`VHR_EXT_SRC_MSB:`VHR_EXT_SRC_LSB],
          mapping_source_entry[g][`VHR_MAP_VC_MSB:`VHR_MAP_VC_LSB]} :
         {2'h0, mapping_source_entry[g][`VHR_MAP_VC_MSB:`VHR_MAP_VC_LSB]};
      assign dst_vc[g] = channel_extension_enable ?
         {ext_entry[g][`VHR_EXT_DST_MSB:`VHR_EXT_DST_LSB],
          mapping_dest_entry[g][`VHR_MAP_VC_MSB:`VHR_MAP_VC_LSB]} :
         {2'h0, mapping_dest_entry[g][`VHR_MAP_VC_MSB:`VHR_MAP_VC_LSB]};
      // low bits from the entry, high bits from extension, or zero with extension off
      assign hit[g] = map_en[g] &&
         (mapping_source_entry[g][`VHR_MAP_DT_MSB:`VHR_MAP_DT_LSB]
          == ov_dt) &&
         (src_vc[g] == (channel_extension_enable ? ov_vc
                                                 : {2'h0, ov_vc[1:0]}));
   end

   // lowest numbered matching entry wins
   logic any_hit;
   logic [3:0] hit_idx;
   always_comb
   begin
      any_hit = 1'b0;
      hit_idx = 4'h0;
      for (int k = MAP_N - 1; k >= 0; k--)
      begin
         if (hit[k])
         begin
            any_hit = 1'b1;
            hit_idx = 4'(k);
         end
      end
   end

   // rewritten header; unmatched words keep the override stage header, channel cut to its low two bits with extension off
   wire [3:0] narrow_vc = channel_extension_enable ? ov_vc
                                                   : {2'h0, ov_vc[1:0]};
   wire [5:0] map_dt = any_hit ?
      mapping_dest_entry[hit_idx][`VHR_MAP_DT_MSB:`VHR_MAP_DT_LSB]
      : ov_dt;
   wire [3:0] map_vc = any_hit ? dst_vc[hit_idx] : narrow_vc;

   // ****************************************************************
   // output buffer
   // ****************************************************************
   wire [BW-1:0] buf_out;
   vhr_skid_buf #(.W(BW)) u_buf (
      .i_sys_clk(i_sys_clk),
      .i_rst(i_rst),
      .i_in_valid(i_pix_valid),
      .o_in_ready(o_pix_ready),
      .i_in_data({map_dt, map_vc, ov_bpp, i_pix_data}),
      .o_out_valid(o_csi_valid),
      .i_out_ready(i_csi_ready),
      .o_out_data(buf_out)
   );
   // fields of the buffered word
   assign o_csi_dt = buf_out[BW-1 -: 6];
   assign o_csi_vc = buf_out[BW-7 -: 4];
   assign o_csi_bpp = buf_out[BW-11 -: 5];
   assign o_csi_data = buf_out[DATA_W-1:0];
   assign o_channel_extension_enable = channel_extension_enable;
   assign o_lane_count = lane_count;

   // ****************************************************************
   // checks
   // ****************************************************************
   a_vcx_reset_off: assert property (
      @(posedge i_sys_clk) i_rst |=> !channel_extension_enable)
      else $error("extension not off after reset");
   a_vcx_write_bit: assert property (
      @(posedge i_sys_clk) disable iff (i_rst)
      i_reg_wr && sel_lane |=>
         channel_extension_enable == $past(i_reg_wdata[`VHR_VCX_BIT]))
      else $error("extension bit not taken from write");
   a_ext_wide_vc: assert property (
      @(posedge i_sys_clk) disable iff (i_rst)
      channel_extension_enable && any_hit |->
         map_vc == {ext_entry[hit_idx][`VHR_EXT_DST_MSB:`VHR_EXT_DST_LSB],
            mapping_dest_entry[hit_idx][`VHR_MAP_VC_MSB:`VHR_MAP_VC_LSB]})
      else $error("wide channel not built from entry and extension");
   a_narrow_vc_off: assert property (
      @(posedge i_sys_clk) disable iff (i_rst)
      !channel_extension_enable |-> map_vc[3:2] == 2'h0)
      else $error("wide channel bits used with extension off");
   a_ovr_applied: assert property (
      @(posedge i_sys_clk) disable iff (i_rst)
      header_override_enable && i_pix_valid && o_pix_ready && !o_csi_valid
      |=> o_csi_bpp == $past(override_bpp_field))
      else $error("override values not applied");
   a_ovr_pass: assert property (
      @(posedge i_sys_clk) disable iff (i_rst)
      !header_override_enable && i_pix_valid && o_pix_ready && !o_csi_valid
      |=> o_csi_bpp == $past(i_pix_bpp) && o_csi_data == $past(i_pix_data))
      else $error("header altered with override off");
   a_ovr_header_out: assert property (
      @(posedge i_sys_clk) disable iff (i_rst)
      header_override_enable && channel_extension_enable && !any_hit &&
         i_pix_valid && o_pix_ready && !o_csi_valid
      |=> o_csi_dt == $past({dt_hi, dt_lo}) &&
         o_csi_vc == $past(override_channel_field))
      else $error("override header not carried to output");
   a_pass_header_out: assert property (
      @(posedge i_sys_clk) disable iff (i_rst)
      !header_override_enable && channel_extension_enable && !any_hit &&
         i_pix_valid && o_pix_ready && !o_csi_valid
      |=> o_csi_dt == $past(i_pix_dt) && o_csi_vc == $past(i_pix_vc))
      else $error("pipe header not passed with override off");
   a_dt_split_hi: assert property (
      @(posedge i_sys_clk) disable iff (i_rst)
      i_reg_wr && sel_dt_hi |=>
         dt_hi == $past(i_reg_wdata[`VHR_DT_HI_MSB:`VHR_DT_HI_LSB]))
      else $error("data type high bits not stored");
   a_ext_readback: assert property (
      @(posedge i_sys_clk) disable iff (i_rst)
      i_reg_rd && sel_ext |=> o_reg_rvalid && o_reg_rdata[1:0] == 2'h0)
      else $error("extension register read wrong");
   a_vc_field_wr: assert property (
      @(posedge i_sys_clk) disable iff (i_rst)
      i_reg_wr && sel_vc ##1 !i_reg_wr [*2] |->
         override_channel_field ==
            $past(i_reg_wdata[`VHR_VC_OVR_MSB:`VHR_VC_OVR_LSB], 2))
      else $error("override channel not held");
   a_vc_field_rd: assert property (
      @(posedge i_sys_clk) disable iff (i_rst)
      i_reg_rd && sel_vc |=>
         o_reg_rvalid && o_reg_rdata == {$past(override_channel_field), 4'h0})
      else $error("override channel read back wrong");
   // destination type of the matched entry, for the output check
   wire [5:0] hit_dst_dt =
      mapping_dest_entry[hit_idx][`VHR_MAP_DT_MSB:`VHR_MAP_DT_LSB];
   a_map_dt_out: assert property (
      @(posedge i_sys_clk) disable iff (i_rst)
      any_hit && i_pix_valid && o_pix_ready && !o_csi_valid |=>
         o_csi_dt == $past(hit_dst_dt))
      else $error("matched entry type not on output");
endmodule

/* verification/vhr_csi_rx.sv */
// model of the output receiver: accepts words, stalls on demand, logs words
module vhr_csi_rx
   import vhr_pkg::*;
(
   input wire logic i_sys_clk,
   input wire logic i_rst,
   input wire logic i_stall,
   input wire logic i_valid,
   output logic o_ready,
   input wire logic [5:0] i_dt,
   input wire logic [3:0] i_vc,
   input wire logic [4:0] i_bpp,
   input wire logic [31:0] i_data
);
   timeunit 1ns;
   timeprecision 100ps;
   // ****************************************************************
   // receive side
   // ****************************************************************
   logic [46:0] got[$];
   // log every accepted word; ready follows the stall request one edge late
   always @(posedge i_sys_clk)
   begin
      if (!i_rst && i_valid === 1'b1 && o_ready)
      begin
         got.push_back({i_dt, i_vc, i_bpp, i_data});
      end
      o_ready <= !i_rst && !i_stall;
   end
endmodule

/* verification/video_header_vc_dt_remap_bench.sv */
// self-checking testbench of the header remapper
`include "vhr_cfg.svh"
module video_header_vc_dt_remap_bench
   import vhr_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   // ****************************************************************
   // signals and instances
   // ****************************************************************
   logic sys_clk, rst, reg_wr, reg_rd, reg_rvalid, pix_valid, pix_ready;
   logic csi_valid, csi_ready, vcx_en, stall;
   vhr_addr_t reg_addr;
   vhr_byte_t reg_wdata, reg_rdata;
   vhr_dt_t pix_dt, csi_dt;
   vhr_vc_t pix_vc, csi_vc;
   vhr_bpp_t pix_bpp, csi_bpp;
   logic [31:0] pix_data, csi_data, seqd;
   logic [1:0] lanes;
   int failures, n_compared;
   vhr_remap #(.DATA_W(32), .MAP_N(16)) vhr_remap_i (.i_sys_clk(sys_clk),
      .i_rst(rst), .i_reg_addr(reg_addr), .i_reg_wr(reg_wr),
      .i_reg_wdata(reg_wdata), .i_reg_rd(reg_rd), .o_reg_rdata(reg_rdata),
      .o_reg_rvalid(reg_rvalid), .i_pix_valid(pix_valid),
      .o_pix_ready(pix_ready), .i_pix_dt(pix_dt), .i_pix_vc(pix_vc),
      .i_pix_bpp(pix_bpp), .i_pix_data(pix_data), .o_csi_valid(csi_valid),
      .i_csi_ready(csi_ready), .o_csi_dt(csi_dt), .o_csi_vc(csi_vc),
      .o_csi_bpp(csi_bpp), .o_csi_data(csi_data),
      .o_channel_extension_enable(vcx_en), .o_lane_count(lanes));
   vhr_csi_rx vhr_csi_rx_i (.i_sys_clk(sys_clk), .i_rst(rst),
      .i_stall(stall), .i_valid(csi_valid), .o_ready(csi_ready),
      .i_dt(csi_dt), .i_vc(csi_vc), .i_bpp(csi_bpp), .i_data(csi_data));
   // ****************************************************************
   // shared tasks
   // ****************************************************************
   task automatic results();
      $display("compared %0d, failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic fail(input string m);
      failures++;
      $display("unexpected at %0t: %s", $time, m);
   endtask
   // register byte compare under a mask of the bits that are defined
   task automatic cmp_byte(input vhr_byte_t got, exp, mask);
      n_compared++;
      if ((got & mask) !== (exp & mask))
         fail($sformatf("byte %h, wanted %h", got, exp));
   endtask
   // header plus data word compare
   task automatic cmp_word(input logic [46:0] got, exp);
      n_compared++;
      if (got !== exp)
         fail($sformatf("word %h, wanted %h", got, exp));
   endtask
   // one register write: strobe high for one edge
   task automatic reg_write(input vhr_addr_t a, input vhr_byte_t d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask
   // one register read, answer awaited under a bounded count
   task automatic reg_check(input vhr_addr_t a, input vhr_byte_t e, m);
      int n;
      n = 0;
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      @(negedge sys_clk);
      while (reg_rvalid !== 1'b1 && n < 4)
      begin
         n++;
         @(negedge sys_clk);
      end
      if (n == 4)
         fail("no read answer");
      else
         cmp_byte(reg_rdata, e, m);
   endtask
   // one stream word: valid held until the edge that takes it
   task automatic send(input vhr_dt_t dt, input vhr_vc_t vc,
                       input vhr_bpp_t bpp, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge sys_clk);
      pix_dt <= dt;
      pix_vc <= vc;
      pix_bpp <= bpp;
      pix_data <= d;
      pix_valid <= 1'b1;
      @(negedge sys_clk);
      while (pix_ready !== 1'b1 && n < 50)
      begin
         n++;
         @(negedge sys_clk);
      end
      if (n == 50)
         fail("input never ready");
      @(posedge sys_clk);
      pix_valid <= 1'b0;
      pix_data <= ~d;
   endtask
   // next word logged by the receiver, awaited under a bounded count
   task automatic take_word(input logic [46:0] e);
      int n;
      n = 0;
      while (vhr_csi_rx_i.got.size() == 0 && n < 50)
      begin
         n++;
         @(negedge sys_clk);
      end
      if (n == 50)
         fail("no word delivered");
      else
         cmp_word(vhr_csi_rx_i.got.pop_front(), e);
   endtask
   // send one word and check the rewritten header that comes out
   task automatic send_chk(input vhr_dt_t dt, vhr_vc_t vc, vhr_bpp_t bpp,
                           input vhr_dt_t edt, vhr_vc_t evc, vhr_bpp_t ebpp);
      seqd = seqd + 32'h1;
      send(dt, vc, bpp, seqd);
      take_word({edt, evc, ebpp, seqd});
   endtask
   // ****************************************************************
   // scenarios
   // ****************************************************************
   task automatic t_reset_values();
      vhr_addr_t al[8] = '{16'h0314, 16'h0317, 16'h0319, 16'h031d,
                           16'h0510, 16'h0517, 16'h051f, 16'h044b};
      cmp_byte({7'h00, vcx_en}, 8'h00, 8'h01);
      cmp_byte({6'h00, lanes}, 8'h03, 8'h03);
      foreach (al[i]) reg_check(al[i], 8'h00, 8'hff);
   endtask
   task automatic t_reg_fields();
      vhr_addr_t al[7] = '{16'h0314, 16'h0316, 16'h0317, 16'h0319,
                           16'h0510, 16'h051f, 16'h0600};
      vhr_byte_t wv[7] = '{8'ha5, 8'hc0, 8'h0a, 8'h15, 8'hff, 8'hff, 8'h55};
      vhr_byte_t ev[7] = '{8'ha0, 8'hc0, 8'h0a, 8'h15, 8'hfc, 8'hfc, 8'h00};
      vhr_byte_t mv[7] = '{8'hf0, 8'hc0, 8'h0f, 8'h1f, 8'hff, 8'hff, 8'hff};
      foreach (al[i]) reg_write(al[i], wv[i]);
      foreach (al[i]) reg_check(al[i], ev[i], mv[i]);
      foreach (al[i]) reg_write(al[i], 8'h00);
   endtask
   task automatic t_override();
      send_chk(6'h2c, 4'h3, 5'h0c, 6'h2c, 4'h3, 5'h0c);
      reg_write(`VHR_A_LANE_VCX, 8'hd0);
      @(negedge sys_clk);
      cmp_byte({7'h00, vcx_en}, 8'h01, 8'h01);
      reg_write(`VHR_A_VC_OVR, 8'ha0);
      reg_write(`VHR_A_DT_OVR_HI, 8'h80);
      reg_write(`VHR_A_DT_OVR_LO, 8'h0c);
      reg_write(`VHR_A_BPP_OVR, 8'h0c);
      reg_write(`VHR_A_OVR_EN, 8'h7f);
      send_chk(6'h01, 4'h5, 5'h08, 6'h01, 4'h5, 5'h08);
      reg_write(`VHR_A_OVR_EN, 8'h80);
      send_chk(6'h01, 4'h5, 5'h08, 6'h2c, 4'ha, 5'h0c);
      reg_write(`VHR_A_VC_OVR, 8'hf0);
      send_chk(6'h01, 4'h5, 5'h08, 6'h2c, 4'hf, 5'h0c);
      reg_write(`VHR_A_DT_OVR_HI, 8'hc0);
      reg_write(`VHR_A_DT_OVR_LO, 8'h0f);
      reg_write(`VHR_A_BPP_OVR, 8'h1f);
      send_chk(6'h01, 4'h5, 5'h08, 6'h3f, 4'hf, 5'h1f);
      reg_write(`VHR_A_OVR_EN, 8'h00);
   endtask
   task automatic t_mapping();
      reg_write(16'h044d, 8'h6c);
      reg_write(16'h044e, 8'ha4);
      reg_write(16'h0510, 8'h64);
      reg_write(16'h046b, 8'hde);
      reg_write(16'h046c, 8'h1e);
      reg_write(16'h051f, 8'h28);
      reg_write(16'h044b, 8'h01);
      reg_write(16'h044c, 8'h80);
      send_chk(6'h2c, 4'hd, 5'h0c, 6'h24, 4'h6, 5'h0c);
      send_chk(6'h2c, 4'h1, 5'h0c, 6'h2c, 4'h1, 5'h0c);
      send_chk(6'h1e, 4'h7, 5'h0a, 6'h1e, 4'h8, 5'h0a);
      reg_write(`VHR_A_LANE_VCX, 8'h40);
      @(negedge sys_clk);
      cmp_byte({5'h00, lanes, vcx_en}, 8'h02, 8'h07);
      send_chk(6'h2c, 4'h1, 5'h0c, 6'h24, 4'h2, 5'h0c);
   endtask
   task automatic t_stall();
      stall <= 1'b1;
      send(6'h2c, 4'h1, 5'h0c, 32'h0000_0a01);
      send(6'h2c, 4'h2, 5'h0c, 32'h0000_0a02);
      fork
         send(6'h2c, 4'h3, 5'h0c, 32'h0000_0a03);
         begin
            repeat (2) @(negedge sys_clk);
            cmp_byte({6'h00, pix_ready, csi_valid}, 8'h01, 8'h03);
            repeat (4) @(posedge sys_clk);
            stall <= 1'b0;
         end
      join
      take_word({6'h24, 4'h2, 5'h0c, 32'h0000_0a01});
      take_word({6'h2c, 4'h2, 5'h0c, 32'h0000_0a02});
      take_word({6'h2c, 4'h3, 5'h0c, 32'h0000_0a03});
   endtask
   // reset in mid-run: settings fall back to their reset values
   task automatic t_rerun_reset();
      reg_write(`VHR_A_LANE_VCX, 8'h10);
      @(posedge sys_clk);
      rst <= 1'b1;
      repeat (2) @(posedge sys_clk);
      rst <= 1'b0;
      @(negedge sys_clk);
      cmp_byte({5'h00, lanes, vcx_en}, 8'h06, 8'h07);
      reg_check(16'h051f, 8'h00, 8'hff);
      send_chk(6'h2c, 4'h5, 5'h0c, 6'h2c, 4'h1, 5'h0c);
   endtask
   // ****************************************************************
   // clock, watchdog and main sequence
   // ****************************************************************
   initial
   begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end
   initial
   begin
      repeat (20000) @(posedge sys_clk);
      fail("watchdog expired");
      results();
   end
   initial
   begin
      rst = 1'b1;
      {reg_wr, reg_rd, pix_valid, stall} = 4'h0;
      reg_addr = 16'h0000;
      reg_wdata = 8'h00;
      {pix_dt, pix_vc, pix_bpp, pix_data} = '0;
      seqd = 32'hc0de_0000;
      failures = 0;
      n_compared = 0;
      repeat (16) @(posedge sys_clk);
      rst <= 1'b0;
      t_reset_values();
      t_reg_fields();
      t_override();
      t_mapping();
      t_stall();
      t_rerun_reset();
      results();
   end
endmodule
